// file: inc/frm_pkg.sv
package frm_pkg;

  // ==========================================================================
  // Sizes and reset values
  // ==========================================================================
  localparam int NUM_PORTS = 7;
  localparam int SYNC_STAGES = 2;
  localparam logic LINK_MASK_RST = 1'h1;
  localparam logic MON_EN_RST = 1'h1;
  localparam logic RING_EN_RST = 1'h0;
  localparam logic ALARM_RST = 1'h1;
  localparam logic RELAY_CLOSED_RST = 1'h0;
  localparam logic [1:0] CONFLICT_HOLD_CYCLES = 2'h2;

  // ==========================================================================
  // Operating roles
  // ==========================================================================
  typedef enum logic [1:0] {
    FRM_MODE_NORMAL,
    FRM_MODE_STANDBY,
    FRM_MODE_RING_MANAGER,
    FRM_MODE_CONFLICT
  } frm_mode_t;

endpackage : frm_pkg

// file: rtl/frm_monitor.sv
`timescale 1ns/1ps

module frm_monitor
  import frm_pkg::*;
#(
  parameter int NUM_PORTS = frm_pkg::NUM_PORTS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic supply1_fail,
  input wire logic supply2_fail,
  input wire logic int_rail_fail,
  input wire logic [NUM_PORTS-1:0] link_down,
  input wire logic ring_lost,
  input wire logic ring_ok,
  input wire logic selftest_err,
  input wire logic cable_broken,
  input wire logic cable_short,
  input wire logic partner_standby,
  input wire logic partner_normal,
  input wire logic standby_sel,
  input wire logic ring_manager_role,
  input wire logic cfg_we,
  input wire logic [NUM_PORTS-1:0] cfg_link_mask,
  input wire logic cfg_supply_en,
  input wire logic cfg_rail_en,
  input wire logic cfg_ring_en,
  input wire logic cfg_selftest_en,
  input wire logic cfg_cable_en,
  output logic relay_closed,
  output logic alarm,
  output logic [NUM_PORTS-1:0] link_mask,
  output logic ring_en,
  output frm_pkg::frm_mode_t mode,
  output logic reset_req
);
  import frm_pkg::*;

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  localparam int NIN = NUM_PORTS + 12;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;

  // Every condition and both mode switches come from pins, so all of them are resynchronised.
  assign raw_in = {
    link_down,
    supply1_fail,
    supply2_fail,
    int_rail_fail,
    ring_lost,
    ring_ok,
    selftest_err,
    cable_broken,
    cable_short,
    partner_standby,
    partner_normal,
    standby_sel,
    ring_manager_role
  };

  frm_sync #(.WIDTH(NIN)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(raw_in),
    .sync_out(syn)
  );

  logic [NUM_PORTS-1:0] s_link_down;
  logic s_sup1;
  logic s_sup2;
  logic s_rail;
  logic s_ring_lost;
  logic s_ring_ok;
  logic s_st;
  logic s_brk;
  logic s_sht;
  logic s_pstby;
  logic s_pnorm;
  logic s_stby;
  logic s_rm;

  assign s_link_down = syn[NIN-1 -: NUM_PORTS];
  assign s_sup1 = syn[11];
  assign s_sup2 = syn[10];
  assign s_rail = syn[9];
  assign s_ring_lost = syn[8];
  assign s_ring_ok = syn[7];
  assign s_st = syn[6];
  assign s_brk = syn[5];
  assign s_sht = syn[4];
  assign s_pstby = syn[3];
  assign s_pnorm = syn[2];
  assign s_stby = syn[1];
  assign s_rm = syn[0];

  // ==========================================================================
  // Configuration
  // ==========================================================================
  logic supply_en_q;
  logic rail_en_q;
  logic selftest_en_q;
  logic cable_en_q;

  // Link masks and the ring enable are ports, so management can read back what it wrote.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      link_mask <= {NUM_PORTS{LINK_MASK_RST}};
      ring_en <= RING_EN_RST;
    end else if (cfg_we) begin
      link_mask <= cfg_link_mask;
      ring_en <= cfg_ring_en;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      supply_en_q <= MON_EN_RST;
      rail_en_q <= MON_EN_RST;
      selftest_en_q <= MON_EN_RST;
      cable_en_q <= MON_EN_RST;
    end else if (cfg_we) begin
      supply_en_q <= cfg_supply_en;
      rail_en_q <= cfg_rail_en;
      selftest_en_q <= cfg_selftest_en;
      cable_en_q <= cfg_cable_en;
    end
  end

  // ==========================================================================
  // Operating mode and conflict reset
  // ==========================================================================
  frm_mode_t mode_d;
  logic [1:0] conflict_cnt_q;

  always_comb begin
    case ({s_stby, s_rm})
      2'h2: mode_d = FRM_MODE_STANDBY;
      2'h1: mode_d = FRM_MODE_RING_MANAGER;
      2'h3: mode_d = FRM_MODE_CONFLICT;
      default: mode_d = FRM_MODE_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mode <= FRM_MODE_NORMAL;
    end else begin
      mode <= mode_d;
    end
  end

  // A conflict must persist a few cycles before reset is asked for, filtering switch bounce.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      conflict_cnt_q <= 2'h0;
      reset_req <= 1'h0;
    end else begin
      if (mode_d != FRM_MODE_CONFLICT) begin
        conflict_cnt_q <= 2'h0;
      end else if (conflict_cnt_q != CONFLICT_HOLD_CYCLES) begin
        conflict_cnt_q <= conflict_cnt_q + 2'h1;
      end
      reset_req <= (mode_d == FRM_MODE_CONFLICT) && (conflict_cnt_q == CONFLICT_HOLD_CYCLES);
    end
  end

  // ==========================================================================
  // Fault collection
  // ==========================================================================
  logic f_supply;
  logic f_rail;
  logic f_link;
  logic f_ring;
  logic f_st;
  logic f_cable;
  logic fault_any;

  always_comb begin
    f_supply = supply_en_q && (s_sup1 || s_sup2);
    f_rail = rail_en_q && s_rail;
    f_link = |(s_link_down & ~link_mask);
    f_ring = ring_en && (s_ring_lost || ((mode_d == FRM_MODE_RING_MANAGER) && s_ring_ok));
    f_st = selftest_en_q && s_st;
    case (mode_d)
      FRM_MODE_STANDBY: f_cable = cable_en_q && (s_brk || s_sht || s_pstby);
      FRM_MODE_NORMAL: f_cable = cable_en_q && (s_sht || s_pnorm);
      default: f_cable = 1'h0;
    endcase
    fault_any = f_supply || f_rail || f_link || f_ring || f_st || f_cable;
  end

  // ==========================================================================
  // Alarm outputs
  // ==========================================================================
  // Both outputs reset to the fault state, so a device held in reset reads as failed.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      alarm <= ALARM_RST;
    end else begin
      alarm <= fault_any;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      relay_closed <= RELAY_CLOSED_RST;
    end else begin
      relay_closed <= !fault_any;
    end
  end
endmodule : frm_monitor

// file: rtl/frm_sync.sv
`timescale 1ns/1ps

// ==========================================================================
// Two-stage synchroniser, one per bit.
// ==========================================================================
module frm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : frm_sync

// file: test/frm_diag_model.sv
`timescale 1ns/1ps
// ====
// Remote equipment that reads the contact loop.
module frm_diag_model (
  input wire logic relay_closed,
  output logic fault_seen
);
  assign fault_seen = !relay_closed;
endmodule : frm_diag_model

// file: test/frm_monitor_properties.sv
`timescale 1ns/1ps
// ====
// Port checker.
module frm_monitor_chk
  import frm_pkg::*;
#(
  parameter int NUM_PORTS = 7
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [NUM_PORTS-1:0] link_down,
  input wire logic standby_sel,
  input wire logic ring_manager_role,
  input wire logic cfg_we,
  input wire logic [NUM_PORTS-1:0] cfg_link_mask,
  input wire logic relay_closed,
  input wire logic alarm,
  input wire logic [NUM_PORTS-1:0] link_mask,
  input wire logic ring_en,
  input wire frm_pkg::frm_mode_t mode,
  input wire logic reset_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_conflict;
    (rstn && standby_sel && ring_manager_role)[*3];
  endsequence
  sequence s_link_fault;
    (rstn && |(link_down & ~link_mask) && $stable(link_down))[*3];
  endsequence
  chk_relay_state: assert property (relay_closed == !alarm)
    else $error("relay and alarm disagree");
  chk_link_alarm: assert property (s_link_fault |=> alarm)
    else $error("link fault not alarmed");
  chk_mask_load: assert property (rstn && cfg_we |=> link_mask == $past(cfg_link_mask))
    else $error("mask not loaded");
  chk_mask_hold: assert property (rstn && !cfg_we |=> $stable(link_mask) && $stable(ring_en))
    else $error("config changed without write");
  chk_reset_vals: assert property ($rose(rstn) |-> link_mask == '1 && !ring_en && alarm && !reset_req)
    else $error("wrong values after reset");
  chk_mode_standby: assert property ((rstn && standby_sel && !ring_manager_role)[*3] |=> mode == FRM_MODE_STANDBY)
    else $error("standby mode not taken");
  chk_mode_ring: assert property ((rstn && !standby_sel && ring_manager_role)[*3] |=> mode == FRM_MODE_RING_MANAGER)
    else $error("ring manager mode not taken");
  chk_mode_normal: assert property ((rstn && !standby_sel && !ring_manager_role)[*3] |=> mode == FRM_MODE_NORMAL)
    else $error("normal mode not taken");
  chk_conflict_mode: assert property (s_conflict |=> mode == FRM_MODE_CONFLICT)
    else $error("conflict not seen");
  chk_reset_req: assert property ($rose(reset_req) |-> $past(mode, 2) == FRM_MODE_CONFLICT)
    else $error("reset request without conflict");
endmodule : frm_monitor_chk

bind frm_monitor frm_monitor_chk #(.NUM_PORTS(NUM_PORTS)) frm_monitor_chk_inst (.ref_clk(ref_clk), .rstn(rstn),
  .link_down(link_down), .standby_sel(standby_sel), .ring_manager_role(ring_manager_role), .cfg_we(cfg_we),
  .cfg_link_mask(cfg_link_mask), .relay_closed(relay_closed), .alarm(alarm), .link_mask(link_mask),
  .ring_en(ring_en), .mode(mode), .reset_req(reset_req));

// file: test/frm_monitor_tb.sv
`timescale 1ns/1ps
// ====
// Bench; a row is {alarm, enables[30:26], masks[25:19], link_down[18:12], conditions[11:0]}.
module frm_monitor_tb;
  import frm_pkg::*;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic cfg_we = 1'h0;
  logic [11:0] cond = 12'h000;
  logic [6:0] ld = 7'h00;
  logic [6:0] mk = 7'h00;
  logic [4:0] en = 5'h00;
  logic relay_closed, alarm, ring_en, reset_req, fault_seen;
  logic [6:0] link_mask;
  frm_mode_t mode;
  int fails = 0;
  int tests_run = 0;
  logic [31:0] rows [26] = '{32'h6ff80000, 32'heff80800, 32'heff80400, 32'h2ff80800, 32'heff80200, 32'heff80100,
    32'h6ff80080, 32'hfff80080, 32'h6ff88000, 32'hefb88000, 32'heff80010, 32'heff80004, 32'h6ff80020, 32'h6ff80008,
    32'h6bf80010, 32'h6ff80002, 32'heff80022, 32'heff80012, 32'heff8000a, 32'h6ff80006, 32'hfff80041, 32'h7ff80040,
    32'h6ff80011, 32'h6ff80000, 32'h4ff80200, 32'h67f80100};
  always #4 ref_clk = ~ref_clk;
  frm_monitor frm_monitor_inst (.ref_clk(ref_clk), .rstn(rstn), .supply1_fail(cond[11]), .supply2_fail(cond[10]),
    .int_rail_fail(cond[9]), .selftest_err(cond[8]), .ring_lost(cond[7]), .ring_ok(cond[6]), .cable_broken(cond[5]),
    .cable_short(cond[4]), .partner_standby(cond[3]), .partner_normal(cond[2]), .standby_sel(cond[1]),
    .ring_manager_role(cond[0]), .link_down(ld), .cfg_we(cfg_we), .cfg_link_mask(mk), .cfg_supply_en(en[4]),
    .cfg_rail_en(en[3]), .cfg_ring_en(en[2]), .cfg_selftest_en(en[1]), .cfg_cable_en(en[0]),
    .relay_closed(relay_closed), .alarm(alarm), .link_mask(link_mask), .ring_en(ring_en), .mode(mode),
    .reset_req(reset_req));
  frm_diag_model frm_diag_model_inst (.relay_closed(relay_closed), .fault_seen(fault_seen));
  task chk(input bit ok);
    tests_run++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t output mismatch", $time);
    end
  endtask : chk
  task apply(input logic [31:0] r);
    @(posedge ref_clk);
    cond <= r[11:0];
    ld <= r[18:12];
    mk <= r[25:19];
    en <= r[30:26];
    cfg_we <= 1'h1;
    @(posedge ref_clk);
    cfg_we <= 1'h0;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : apply
  task do_reset;
    @(posedge ref_clk);
    rstn <= 1'h0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'h1;
    #1;
  endtask : do_reset
  task test_done;
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    do_reset();
    chk(link_mask === 7'h7f && ring_en === 1'h0 && alarm === 1'h1 && relay_closed === 1'h0);
    chk(mode === FRM_MODE_NORMAL && reset_req === 1'h0);
    foreach (rows[i]) begin
      apply(rows[i]);
      chk(alarm === rows[i][31] && relay_closed === !rows[i][31] && fault_seen === rows[i][31]);
    end
    apply(32'h7c000013);
    chk(mode === FRM_MODE_CONFLICT && reset_req === 1'h1);
    chk(alarm === 1'h0 && link_mask === 7'h00 && ring_en === 1'h1);
    do_reset();
    chk(link_mask === 7'h7f && ring_en === 1'h0 && reset_req === 1'h0 && mode === FRM_MODE_NORMAL);
    repeat (4) @(posedge ref_clk);
    #1;
    chk(mode === FRM_MODE_CONFLICT && reset_req === 1'h0);
    @(posedge ref_clk);
    #1;
    chk(reset_req === 1'h1);
    test_done();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    $display("[FAIL] %0t watchdog timeout", $time);
    fails++;
    test_done();
  end
endmodule : frm_monitor_tb
